/* File: hw/mis_pkg.sv */
// constants and carrier types for the MAC interrupt mask and status block
package mis_pkg;

  // register byte addresses on the system bus
  localparam logic [31:0] MIS_ENABLE_ADDR = 32'hfff030ac;
  localparam logic [31:0] MIS_STATUS_ADDR = 32'hfff030b0;

  // reset values
  localparam logic [31:0] MIS_ENABLE_RST  = 32'h00000000;
  localparam logic [31:0] MIS_STATUS_RST  = 32'h00000000;

  // summary and master enable positions
  localparam int unsigned MIS_TX_SUM_BIT  = 16;
  localparam int unsigned MIS_RX_SUM_BIT  = 0;

  // individual flag positions
  localparam int unsigned MIS_TX_BUS_FAULT     = 24;
  localparam int unsigned MIS_TX_DESC_MISSING  = 23;
  localparam int unsigned MIS_LATE_COLLISION   = 22;
  localparam int unsigned MIS_TX_ABORT         = 21;
  localparam int unsigned MIS_NO_CARRIER       = 20;
  localparam int unsigned MIS_DEFER_EXCEED     = 19;
  localparam int unsigned MIS_TX_COMPLETE      = 18;
  localparam int unsigned MIS_TX_UNDERFLOW     = 17;
  localparam int unsigned MIS_PAUSE_FRAME_RX   = 14;
  localparam int unsigned MIS_RX_BUS_FAULT     = 11;
  localparam int unsigned MIS_RX_DESC_MISSING  = 10;
  localparam int unsigned MIS_EARLY_NOTIFY     = 9;
  localparam int unsigned MIS_OVERSIZE_FRAME   = 8;
  localparam int unsigned MIS_MISS_CNT_WRAP    = 7;
  localparam int unsigned MIS_RUNT_FRAME       = 6;
  localparam int unsigned MIS_ALIGNMENT_FAULT  = 5;
  localparam int unsigned MIS_RX_GOOD          = 4;
  localparam int unsigned MIS_FRAME_TOO_LONG   = 3;
  localparam int unsigned MIS_RX_FIFO_OVERFLOW = 2;
  localparam int unsigned MIS_CHECKSUM_FAULT   = 1;

  // field groups: tx flags 24..17, rx flags 14 and 11..1
  localparam logic [31:0] MIS_TX_FLAGS    = 32'h01fe0000;
  localparam logic [31:0] MIS_RX_FLAGS    = 32'h00004ffe;
  localparam logic [31:0] MIS_MASTER_BITS = 32'h00010001;
  localparam logic [31:0] MIS_ENABLE_BITS = MIS_TX_FLAGS | MIS_RX_FLAGS | MIS_MASTER_BITS;

  localparam logic [31:0] MIS_ZERO_WORD   = 32'h00000000;

  // classic wishbone request, as driven by the master
  typedef struct packed {
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic [31:0] adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i;
  } mis_wb_req_s;

  // the whole state of the block
  typedef struct packed {
    logic        ack;
    logic [31:0] rdData;
    logic [31:0] enable;
    logic [31:0] status;
    logic        txIrq;
    logic        rxIrq;
  } mis_state_s;

endpackage

/* File: hw/mis_mac_irq.sv */
// mac interrupt mask and status registers with tx and rx cpu interrupt lines
// How it works
// (RL1) defer-exceed flag reaches tx summary only when its enable is set
// (RL2) tx-complete flag reaches tx summary only when its enable is set
// (RL3) tx-underflow flag reaches tx summary only when its enable is set
// (RL4) tx interrupt stays low while the tx master enable is clear
// (RL5) pause-frame flag reaches rx summary only when its enable is set
// (RL6) rx bus fault flag reaches rx summary only when its enable is set
// (RL7) rx descriptor missing flag reaches rx summary only when enabled
// (RL8) early notify flag reaches rx summary only when its enable is set
// (RL9) oversize frame flag reaches rx summary only when its enable is set
// (RL10) miss counter wrap flag reaches rx summary only when enabled
// (RL11) runt frame flag reaches rx summary only when its enable is set
// (RL12) alignment fault flag reaches rx summary only when enabled
// (RL13) rx good flag reaches rx summary only when its enable is set
// (RL14) frame too long flag reaches rx summary only when enabled
// (RL15) rx fifo overflow flag reaches rx summary only when enabled
// (RL16) checksum fault flag reaches rx summary only when enabled
// (RL17) rx interrupt stays low while the rx master enable is clear
// (RL18) writing one to a status bit clears it and its interrupt
// (RL19) status flags set by tx, rx, fifo and dma events drive interrupts
// (RL20) status at its address, resets to zero, tx bits 24..16, rx 14..0
// (RL21) tx summary is OR of enabled flags 24..17
// (RL22) rx summary is OR of enabled flags 14..1
// (RL23) interrupt lines are levels held until contributing flags clear
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps

module mis_mac_irq
(
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic                 clkEn,
  input  wire mis_pkg::mis_wb_req_s wbReq,
  input  wire logic [31:0]          eventSet,
  output logic                      ack_o,
  output logic [31:0]               dat_o,
  output logic                      txIrq,
  output logic                      rxIrq
);
  import mis_pkg::*;

  mis_state_s  state_r;
  mis_state_s  state_nxt;

  logic        busReq;
  logic        hitEnable;
  logic        hitStatus;
  logic        wrCommit;
  logic [31:0] byteMask;
  logic [31:0] gatedFlags;
  logic        txSummary;
  logic        rxSummary;
  logic [31:0] statusView;
  logic [31:0] clearBits;
  logic [31:0] statusAfter;
  logic [31:0] gatedAfter;

  // byte lanes expanded to a bit mask for writes
  always_comb
  begin
    byteMask = {{8{wbReq.sel_i[3]}}, {8{wbReq.sel_i[2]}},
                {8{wbReq.sel_i[1]}}, {8{wbReq.sel_i[0]}}};
  end

  // address decode; unmapped addresses still get an ack, read as zero
  assign busReq    = wbReq.cyc_i & wbReq.stb_i;
  assign hitEnable = (wbReq.adr_i == MIS_ENABLE_ADDR);
  assign hitStatus = (wbReq.adr_i == MIS_STATUS_ADDR);
  // a write lands at the edge where the master sees ack high
  assign wrCommit  = busReq & wbReq.we_i & state_r.ack;

  // summary and reserved positions never carry a gated source
  assign gatedFlags[31:25] = 7'h00;
  assign gatedFlags[16:15] = 2'h0;
  assign gatedFlags[13:12] = 2'h0;
  assign gatedFlags[0]     = 1'b0;

  // tx bus fault into tx
  mis_flag_gate u_mis_flag_gate_24
  (
    .statusBit (state_r.status[MIS_TX_BUS_FAULT]),
    .enableBit (state_r.enable[MIS_TX_BUS_FAULT]),
    .gatedBit  (gatedFlags[MIS_TX_BUS_FAULT])
  ); // see (RL21)

  // tx descriptor missing into tx
  mis_flag_gate u_mis_flag_gate_23
  (
    .statusBit (state_r.status[MIS_TX_DESC_MISSING]),
    .enableBit (state_r.enable[MIS_TX_DESC_MISSING]),
    .gatedBit  (gatedFlags[MIS_TX_DESC_MISSING])
  ); // see (RL21)

  // late collision into tx
  mis_flag_gate u_mis_flag_gate_22
  (
    .statusBit (state_r.status[MIS_LATE_COLLISION]),
    .enableBit (state_r.enable[MIS_LATE_COLLISION]),
    .gatedBit  (gatedFlags[MIS_LATE_COLLISION])
  ); // see (RL21)

  // tx abort into tx
  mis_flag_gate u_mis_flag_gate_21
  (
    .statusBit (state_r.status[MIS_TX_ABORT]),
    .enableBit (state_r.enable[MIS_TX_ABORT]),
    .gatedBit  (gatedFlags[MIS_TX_ABORT])
  ); // see (RL21)

  // no carrier into tx
  mis_flag_gate u_mis_flag_gate_20
  (
    .statusBit (state_r.status[MIS_NO_CARRIER]),
    .enableBit (state_r.enable[MIS_NO_CARRIER]),
    .gatedBit  (gatedFlags[MIS_NO_CARRIER])
  ); // see (RL21)

  // defer exceed into tx
  mis_flag_gate u_mis_flag_gate_19
  (
    .statusBit (state_r.status[MIS_DEFER_EXCEED]),
    .enableBit (state_r.enable[MIS_DEFER_EXCEED]),
    .gatedBit  (gatedFlags[MIS_DEFER_EXCEED])
  ); // see (RL1)

  // tx complete into tx
  mis_flag_gate u_mis_flag_gate_18
  (
    .statusBit (state_r.status[MIS_TX_COMPLETE]),
    .enableBit (state_r.enable[MIS_TX_COMPLETE]),
    .gatedBit  (gatedFlags[MIS_TX_COMPLETE])
  ); // see (RL2)

  // tx underflow into tx
  mis_flag_gate u_mis_flag_gate_17
  (
    .statusBit (state_r.status[MIS_TX_UNDERFLOW]),
    .enableBit (state_r.enable[MIS_TX_UNDERFLOW]),
    .gatedBit  (gatedFlags[MIS_TX_UNDERFLOW])
  ); // see (RL3)

  // pause frame into rx
  mis_flag_gate u_mis_flag_gate_14
  (
    .statusBit (state_r.status[MIS_PAUSE_FRAME_RX]),
    .enableBit (state_r.enable[MIS_PAUSE_FRAME_RX]),
    .gatedBit  (gatedFlags[MIS_PAUSE_FRAME_RX])
  ); // see (RL5)

  // rx bus fault into rx
  mis_flag_gate u_mis_flag_gate_11
  (
    .statusBit (state_r.status[MIS_RX_BUS_FAULT]),
    .enableBit (state_r.enable[MIS_RX_BUS_FAULT]),
    .gatedBit  (gatedFlags[MIS_RX_BUS_FAULT])
  ); // see (RL6)

  // rx descriptor missing into rx
  mis_flag_gate u_mis_flag_gate_10
  (
    .statusBit (state_r.status[MIS_RX_DESC_MISSING]),
    .enableBit (state_r.enable[MIS_RX_DESC_MISSING]),
    .gatedBit  (gatedFlags[MIS_RX_DESC_MISSING])
  ); // see (RL7)

  // early notify into rx
  mis_flag_gate u_mis_flag_gate_9
  (
    .statusBit (state_r.status[MIS_EARLY_NOTIFY]),
    .enableBit (state_r.enable[MIS_EARLY_NOTIFY]),
    .gatedBit  (gatedFlags[MIS_EARLY_NOTIFY])
  ); // see (RL8)

  // oversize frame into rx
  mis_flag_gate u_mis_flag_gate_8
  (
    .statusBit (state_r.status[MIS_OVERSIZE_FRAME]),
    .enableBit (state_r.enable[MIS_OVERSIZE_FRAME]),
    .gatedBit  (gatedFlags[MIS_OVERSIZE_FRAME])
  ); // see (RL9)

  // miss counter wrap into rx
  mis_flag_gate u_mis_flag_gate_7
  (
    .statusBit (state_r.status[MIS_MISS_CNT_WRAP]),
    .enableBit (state_r.enable[MIS_MISS_CNT_WRAP]),
    .gatedBit  (gatedFlags[MIS_MISS_CNT_WRAP])
  ); // see (RL10)

  // runt frame into rx
  mis_flag_gate u_mis_flag_gate_6
  (
    .statusBit (state_r.status[MIS_RUNT_FRAME]),
    .enableBit (state_r.enable[MIS_RUNT_FRAME]),
    .gatedBit  (gatedFlags[MIS_RUNT_FRAME])
  ); // see (RL11)

  // alignment fault into rx
  mis_flag_gate u_mis_flag_gate_5
  (
    .statusBit (state_r.status[MIS_ALIGNMENT_FAULT]),
    .enableBit (state_r.enable[MIS_ALIGNMENT_FAULT]),
    .gatedBit  (gatedFlags[MIS_ALIGNMENT_FAULT])
  ); // see (RL12)

  // rx good into rx
  mis_flag_gate u_mis_flag_gate_4
  (
    .statusBit (state_r.status[MIS_RX_GOOD]),
    .enableBit (state_r.enable[MIS_RX_GOOD]),
    .gatedBit  (gatedFlags[MIS_RX_GOOD])
  ); // see (RL13)

  // frame too long into rx
  mis_flag_gate u_mis_flag_gate_3
  (
    .statusBit (state_r.status[MIS_FRAME_TOO_LONG]),
    .enableBit (state_r.enable[MIS_FRAME_TOO_LONG]),
    .gatedBit  (gatedFlags[MIS_FRAME_TOO_LONG])
  ); // see (RL14)

  // rx fifo overflow into rx
  mis_flag_gate u_mis_flag_gate_2
  (
    .statusBit (state_r.status[MIS_RX_FIFO_OVERFLOW]),
    .enableBit (state_r.enable[MIS_RX_FIFO_OVERFLOW]),
    .gatedBit  (gatedFlags[MIS_RX_FIFO_OVERFLOW])
  ); // see (RL15)

  // checksum fault into rx
  mis_flag_gate u_mis_flag_gate_1
  (
    .statusBit (state_r.status[MIS_CHECKSUM_FAULT]),
    .enableBit (state_r.enable[MIS_CHECKSUM_FAULT]),
    .gatedBit  (gatedFlags[MIS_CHECKSUM_FAULT])
  ); // see (RL16)

  // tx summary: any enabled tx source, see (RL21)
  always_comb
  begin
    txSummary = gatedFlags[MIS_TX_BUS_FAULT]
              | gatedFlags[MIS_TX_DESC_MISSING]
              | gatedFlags[MIS_LATE_COLLISION]
              | gatedFlags[MIS_TX_ABORT]
              | gatedFlags[MIS_NO_CARRIER]
              | gatedFlags[MIS_DEFER_EXCEED]
              | gatedFlags[MIS_TX_COMPLETE]
              | gatedFlags[MIS_TX_UNDERFLOW];
  end

  // rx summary: any enabled rx source, see (RL22)
  always_comb
  begin
    rxSummary = gatedFlags[MIS_PAUSE_FRAME_RX]
              | gatedFlags[MIS_RX_BUS_FAULT]
              | gatedFlags[MIS_RX_DESC_MISSING]
              | gatedFlags[MIS_EARLY_NOTIFY]
              | gatedFlags[MIS_OVERSIZE_FRAME]
              | gatedFlags[MIS_MISS_CNT_WRAP]
              | gatedFlags[MIS_RUNT_FRAME]
              | gatedFlags[MIS_ALIGNMENT_FAULT]
              | gatedFlags[MIS_RX_GOOD]
              | gatedFlags[MIS_FRAME_TOO_LONG]
              | gatedFlags[MIS_RX_FIFO_OVERFLOW]
              | gatedFlags[MIS_CHECKSUM_FAULT];
  end

  // status as software reads it: summaries are live, not stored
  always_comb
  begin
    statusView                 = state_r.status & (MIS_TX_FLAGS | MIS_RX_FLAGS);
    statusView[MIS_TX_SUM_BIT] = txSummary; // see (RL20)
    statusView[MIS_RX_SUM_BIT] = rxSummary;
  end

  // write-one-to-clear on the status register, see (RL18)
  assign clearBits = (wrCommit && hitStatus) ? (wbReq.dat_i & byteMask) : MIS_ZERO_WORD;

  // new events win over a clear in the same cycle, see (RL19)
  assign statusAfter = ((state_r.status & ~clearBits) | eventSet)
                       & (MIS_TX_FLAGS | MIS_RX_FLAGS);

  // enables as they will stand after this edge
  always_comb
  begin
    state_nxt = state_r;
    if (wrCommit && hitEnable)
    begin
      state_nxt.enable = ((state_r.enable & ~byteMask) | (wbReq.dat_i & byteMask))
                         & MIS_ENABLE_BITS;
    end
    state_nxt.status = statusAfter;

    // single-cycle ack; drops the cycle after it was given
    state_nxt.ack = busReq & ~state_r.ack;
    if (busReq && !state_r.ack)
    begin
      if (hitEnable)
      begin
        state_nxt.rdData = state_r.enable;
      end
      else if (hitStatus)
      begin
        state_nxt.rdData = statusView;
      end
      else
      begin
        state_nxt.rdData = MIS_ZERO_WORD;
      end
    end
    else
    begin
      state_nxt.rdData = MIS_ZERO_WORD; // data stands only beside ack
    end

    // lines follow the next status, so a clear drops them at the same edge
    state_nxt.txIrq = state_nxt.enable[MIS_TX_SUM_BIT]
                      & (|gatedAfter[31:MIS_TX_SUM_BIT + 1]); // see (RL4) (RL23)
    state_nxt.rxIrq = state_nxt.enable[MIS_RX_SUM_BIT]
                      & (|gatedAfter[MIS_TX_SUM_BIT - 1:MIS_RX_SUM_BIT + 1]); // see (RL17)
  end

  // next gated flags, kept separate to avoid a loop through state_nxt
  always_comb
  begin
    gatedAfter = statusAfter & (MIS_TX_FLAGS | MIS_RX_FLAGS);
    if (wrCommit && hitEnable)
    begin
      gatedAfter = gatedAfter & ((state_r.enable & ~byteMask) | (wbReq.dat_i & byteMask));
    end
    else
    begin
      gatedAfter = gatedAfter & state_r.enable;
    end
  end

  // one register for all state; clkEn low freezes everything except a reset
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_r.ack    <= 1'b0;
      state_r.rdData <= MIS_ZERO_WORD;
      state_r.enable <= MIS_ENABLE_RST;
      state_r.status <= MIS_STATUS_RST; // see (RL20)
      state_r.txIrq  <= 1'b0;
      state_r.rxIrq  <= 1'b0;
    end
    else if (clkEn)
    begin
      state_r <= state_nxt;
    end
  end

  assign ack_o = state_r.ack;
  assign dat_o = state_r.rdData;
  assign txIrq = state_r.txIrq;
  assign rxIrq = state_r.rxIrq;

endmodule

// one source gated by its own enable bit
module mis_flag_gate
(
  input  wire logic statusBit,
  input  wire logic enableBit,
  output logic      gatedBit
);
  // a held flag only counts while its enable is set
  assign gatedBit = statusBit & enableBit;
endmodule

/* File: sim/mis_mac_irq_props.sv */
// port assertions for the mac interrupt mask and status block
`timescale 1ns/1ps
module mis_mac_irq_props
(
  input wire logic                 sys_clk,
  input wire logic                 reset,
  input wire logic                 clkEn,
  input wire mis_pkg::mis_wb_req_s wbReq,
  input wire logic [31:0]          eventSet,
  input wire logic                 ack_o,
  input wire logic [31:0]          dat_o,
  input wire logic                 txIrq,
  input wire logic                 rxIrq
);
  import mis_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // a committed write is the only software path that moves a line
  wire busWr = ack_o && wbReq.we_i;
  wire txEv  = |(eventSet & MIS_TX_FLAGS);
  wire rxEv  = |(eventSet & MIS_RX_FLAGS);
  property p_ackAns; clkEn && wbReq.cyc_i && wbReq.stb_i && !ack_o |=> ack_o; endproperty
  a_ackAns: assert property (p_ackAns) else $error("ack missing");
  property p_ackOne; clkEn && ack_o |=> !ack_o; endproperty
  a_ackOne: assert property (p_ackOne) else $error("ack too long");
  property p_datIdle; !ack_o |-> dat_o == MIS_ZERO_WORD; endproperty
  a_datIdle: assert property (p_datIdle) else $error("data not idle");
  property p_txUp; $rose(txIrq) |-> $past(txEv || busWr); endproperty
  a_txUp: assert property (p_txUp) else $error("tx line rose alone");
  property p_txDn; $fell(txIrq) |-> $past(busWr); endproperty
  a_txDn: assert property (p_txDn) else $error("tx line fell alone");
  property p_rxUp; $rose(rxIrq) |-> $past(rxEv || busWr); endproperty
  a_rxUp: assert property (p_rxUp) else $error("rx line rose alone");
  property p_rxDn; $fell(rxIrq) |-> $past(busWr); endproperty
  a_rxDn: assert property (p_rxDn) else $error("rx line fell alone");
  property p_rstQuiet; disable iff (1'b0) reset |=> !txIrq && !rxIrq && !ack_o; endproperty
  a_rstQuiet: assert property (p_rstQuiet) else $error("busy in reset");
endmodule

/* File: sim/mis_cpu_intc.sv */
// cpu interrupt controller model counting raised interrupt lines
`timescale 1ns/1ps
module mis_cpu_intc
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       txIrq,
  input  wire logic       rxIrq,
  output logic      [7:0] txCnt,
  output logic      [7:0] rxCnt
);
  logic txSeen_r, rxSeen_r;
  // lines are levels, so one assertion counts once however long it stays
  always_ff @(posedge sys_clk)
  begin
    txSeen_r <= !reset && txIrq;
    rxSeen_r <= !reset && rxIrq;
    txCnt    <= reset ? 8'h00 : txCnt + 8'(txIrq && !txSeen_r);
    rxCnt    <= reset ? 8'h00 : rxCnt + 8'(rxIrq && !rxSeen_r);
  end
endmodule

/* File: sim/mis_mac_irq_tb_top.sv */
// self-checking bench for the mac interrupt mask and status block
`timescale 1ns/1ps
module mis_mac_irq_tb_top;
  import mis_pkg::*;
  localparam logic [31:0] SRC = MIS_TX_FLAGS | MIS_RX_FLAGS;
  logic        sys_clk = 0, reset = 1, clkEn = 1, ack_o, txIrq, rxIrq;
  mis_wb_req_s wbReq = '0;
  logic [31:0] eventSet = '0, dat_o, rd;
  logic [7:0]  txCnt, rxCnt;
  int          errorCnt = 0, checkCount = 0;
  mis_mac_irq u_mis_mac_irq (.sys_clk, .reset, .clkEn, .wbReq, .eventSet, .ack_o, .dat_o,
    .txIrq, .rxIrq);
  mis_cpu_intc u_mis_cpu_intc (.sys_clk, .reset, .txIrq, .rxIrq, .txCnt, .rxCnt);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checkCount++;
    if (g !== e)
    begin
      errorCnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // classic single cycle; holds everything until ack is sampled
  task automatic wb(logic we, logic [31:0] a, logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge sys_clk);
    wbReq <= '{1'b1, 1'b1, we, a, 4'hf, d};
    @(posedge sys_clk);
    while (ack_o !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 50)
    begin
      errorCnt++;
      $display("unexpected ack exp 1 got %b", ack_o);
    end
    q = dat_o;
    wbReq <= '0;
    #1;
  endtask
  task automatic pulse(logic [31:0] v);
    @(posedge sys_clk);
    eventSet <= v;
    @(posedge sys_clk);
    eventSet <= '0;
    #1;
  endtask
  function automatic logic irqOf(logic tx);
    return tx ? txIrq : rxIrq;
  endfunction
  task automatic t_reset();
    wb(0, MIS_ENABLE_ADDR, 0, rd);
    chk("enable rst", MIS_ENABLE_RST, rd);
    wb(0, MIS_STATUS_ADDR, 0, rd);
    chk("status rst", MIS_STATUS_RST, rd);
    wb(1, MIS_ENABLE_ADDR + 8, '1, rd);
    chk("unmapped", 0, rd);
    wb(1, MIS_ENABLE_ADDR, '1, rd);
    wb(0, MIS_ENABLE_ADDR, 0, rd);
    chk("enable rw", MIS_ENABLE_BITS, rd);
    $display("test reset done");
  endtask
  // one source: per-source mask, master mask, summary, write-one clear
  task automatic t_source(int b);
    logic [31:0] m = 32'h1 << b;
    logic        tx = b > 16;
    logic [31:0] s = 32'h1 << (tx ? MIS_TX_SUM_BIT : MIS_RX_SUM_BIT);
    wb(1, MIS_ENABLE_ADDR, s, rd);
    pulse(m);
    chk("masked", 0, irqOf(tx));
    wb(0, MIS_STATUS_ADDR, 0, rd);
    chk("stored", m, rd);
    wb(1, MIS_ENABLE_ADDR, m, rd);
    chk("master off", 0, irqOf(tx));
    wb(0, MIS_STATUS_ADDR, 0, rd);
    chk("summary", m | s, rd);
    wb(1, MIS_ENABLE_ADDR, m | s, rd);
    chk("raised", 1, irqOf(tx));
    wb(1, MIS_STATUS_ADDR, m, rd);
    chk("cleared", 0, irqOf(tx));
    wb(0, MIS_STATUS_ADDR, 0, rd);
    chk("status clr", 0, rd);
    $display("test source %0d done", b);
  endtask
  // clock enable freeze, then a reset in mid-run
  task automatic t_freeze();
    wb(1, MIS_ENABLE_ADDR, MIS_ENABLE_BITS, rd);
    @(posedge sys_clk);
    clkEn <= 0;
    pulse(32'h1 << MIS_TX_COMPLETE);
    chk("frozen", 0, txIrq);
    @(posedge sys_clk);
    clkEn <= 1;
    pulse(32'h1 << MIS_TX_COMPLETE);
    chk("tx set", 1, txIrq);
    @(posedge sys_clk);
    reset <= 1;
    repeat (2) @(posedge sys_clk);
    reset <= 0;
    #1;
    chk("tx rst", 0, txIrq);
    wb(0, MIS_STATUS_ADDR, 0, rd);
    chk("status rst2", MIS_STATUS_RST, rd);
    wb(0, MIS_ENABLE_ADDR, 0, rd);
    chk("enable rst2", MIS_ENABLE_RST, rd);
    $display("test freeze done");
  endtask
  task automatic testDone();
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset <= 0;
    t_reset();
    for (int b = 1; b < 25; b++)
      if (SRC[b])
        t_source(b);
    chk("tx raises", 8, txCnt);
    chk("rx raises", 12, rxCnt);
    t_freeze();
    testDone();
  end
  initial
  begin
    #50000;
    errorCnt++;
    testDone();
  end
endmodule
bind mis_mac_irq mis_mac_irq_props u_mis_mac_irq_props (.sys_clk, .reset, .clkEn, .wbReq,
  .eventSet, .ack_o, .dat_o, .txIrq, .rxIrq);
